// ### rtl/dts_seq_regs.vh
// Timing and encoding constants for the termination supply sequencer.
// Assumes a 10 MHz ref_clk; included by bare name from rtl/.
`ifndef DTS_SEQ_REGS_VH
`define DTS_SEQ_REGS_VH

// Clock period in ns
`define DTS_CLK_NS          100
// Power-good reset delay, ms
`define DTS_PG_DELAY_MS     10
// Over-current limit timer, ms
`define DTS_OC_LIMIT_MS     10
// Retry timeout, ms
`define DTS_RETRY_MS        100
// Over/under-voltage filter, us
`define DTS_UVOV_FILT_US    20
// Soft start duration (min), us
`define DTS_SS_US           1300
// Settle time after bias enable before releasing POR, us
`define DTS_BIAS_US         10

// Cycle counts derived from times and clock period
`define DTS_PG_DELAY_CYC    ((`DTS_PG_DELAY_MS * 1000000) / `DTS_CLK_NS)
`define DTS_OC_LIMIT_CYC    ((`DTS_OC_LIMIT_MS * 1000000) / `DTS_CLK_NS)
`define DTS_RETRY_CYC       ((`DTS_RETRY_MS * 1000000) / `DTS_CLK_NS)
`define DTS_UVOV_FILT_CYC   ((`DTS_UVOV_FILT_US * 1000 + `DTS_CLK_NS - 1) / `DTS_CLK_NS)
`define DTS_SS_CYC          ((`DTS_SS_US * 1000 + `DTS_CLK_NS - 1) / `DTS_CLK_NS)
`define DTS_BIAS_CYC        ((`DTS_BIAS_US * 1000 + `DTS_CLK_NS - 1) / `DTS_CLK_NS)

// Rate select code width and default (pin grounded = top rate)
`define DTS_RATE_W          4
`define DTS_RATE_TOP        4'h0

// Mode encoding on the reported mode port
`define DTS_MODE_NORMAL     2'h0
`define DTS_MODE_STANDBY    2'h1
`define DTS_MODE_SHUTDOWN   2'h2

`endif

// ### rtl/dts_seq_filter.v
// Persistence filter: output follows input only after it held steady.
// Assumes a synchronous input and a synchronous active-low reset.
`timescale 1ns/1ps
module dts_seq_filter #(
  parameter CNT_W = 8,                  // Counter width
  parameter DELAY = 200                 // Cycles the input must hold
) (
  input  wire ref_clk,                  // System clock
  input  wire rstn,                     // Sync reset, active low
  input  wire clear,                    // Force output low
  input  wire rawIn,                    // Unfiltered condition
  output reg  filtOut_r                 // Confirmed condition
);

  reg [CNT_W-1:0] holdCnt_r;            // Cycles since input changed

  // ==========================================================
  // Filter counter
  // Input must differ from output for DELAY cycles to flip it.
  always @(posedge ref_clk) begin
    if (!rstn || clear) begin
      holdCnt_r <= {CNT_W{1'b0}};
      filtOut_r <= 1'b0;
    end else if (rawIn == filtOut_r) begin
      holdCnt_r <= {CNT_W{1'b0}};       // Agreement restarts the count
    end else if (holdCnt_r >= DELAY[CNT_W-1:0] - 1'b1) begin
      holdCnt_r <= {CNT_W{1'b0}};
      filtOut_r <= rawIn;
    end else begin
      holdCnt_r <= holdCnt_r + 1'b1;
    end
  end

endmodule

// ### rtl/dts_seq_ctrl.v
// Mode and start-up sequencer of the termination switching supply.
// Assumes all inputs synchronous to ref_clk; analog blocks obey the enables.
`timescale 1ns/1ps
`include "dts_seq_regs.vh"

module dts_seq_ctrl #(
  parameter PG_DELAY_CYC = `DTS_PG_DELAY_CYC,   // Power-good reset delay
  parameter OC_LIMIT_CYC = `DTS_OC_LIMIT_CYC,   // Current limit timer
  parameter RETRY_CYC    = `DTS_RETRY_CYC,      // Fault retry timeout
  parameter SS_CYC       = `DTS_SS_CYC,         // Soft start length
  parameter BIAS_CYC     = `DTS_BIAS_CYC,       // Bias settle time
  parameter FILT_CYC     = `DTS_UVOV_FILT_CYC,  // Voltage fault filter
  parameter TMR_W        = 21                   // Shared timer width
) (
  input  wire                  ref_clk,              // 10 MHz clock
  input  wire                  rstn,                 // Sync reset, active low
  input  wire                  standby_request_n,    // Standby request, low active
  input  wire                  shutdown_request_n,   // Shutdown request, low active
  input  wire                  supplyInRange,        // Input supply within range
  input  wire [`DTS_RATE_W-1:0] switch_rate_select,  // Digitised rate pin level
  input  wire                  outputInRegulation,   // Output reached regulation
  input  wire                  overVoltRaw,          // Unfiltered over-voltage
  input  wire                  underVoltRaw,         // Unfiltered under-voltage
  input  wire                  currentLimitHit,      // Peak current at limit
  input  wire                  shortCircuitHit,      // Short-circuit level reached
  input  wire                  overTemp,             // Thermal limit, with hysteresis
  output reg                   power_ok_n_o_r,       // Power-good pin output level
  output reg                   power_ok_n_oe_r,      // Power-good drive enable
  output reg                   biasEnable_r,         // Internal supply and bias on
  output reg                   porRelease_r,         // Internal POR released
  output reg                   blocksEnable_r,       // Remaining blocks enabled
  output reg                   converterEnable_r,    // Buck converter switching
  output reg                   softStart_r,          // Soft start ramp active
  output reg                   refOutEnable_r,       // Reference buffer on
  output reg                   termHighZ_r,          // Termination output hi-Z
  output reg                   termDischarge_r,      // Termination discharge switch
  output reg                   refDischarge_r,       // Reference discharge switch
  output reg                   cycleLimit_r,         // Cycle-by-cycle limit active
  output reg [`DTS_RATE_W-1:0] rateLatched_r,        // Latched switching rate code
  output reg [1:0]             mode_r,               // Current operating mode
  output reg                   faultStatus_r         // Any fault present
);

  // ==========================================================
  // States, one-hot
  localparam ST_W      = 8;
  localparam S_OFF     = 8'h01;          // Shutdown, nothing powered
  localparam S_BIAS    = 8'h02;          // Standby, bias and reference only
  localparam S_RATE    = 8'h04;          // POR released, reading rate
  localparam S_SOFT    = 8'h08;          // Soft start ramp
  localparam S_WAITREG = 8'h10;          // Ramp done, awaiting regulation
  localparam S_PGDLY   = 8'h20;          // Reset delay before power-good
  localparam S_RUN     = 8'h40;          // Normal operation
  localparam S_RETRY   = 8'h80;          // Output off, retry timeout

  // State groups; one-hot, so a mask test decodes each
  localparam SET_LOW   = S_OFF | S_BIAS;                      // Bias at most
  localparam SET_CONV  = S_SOFT | S_WAITREG | S_PGDLY | S_RUN; // Switching
  localparam SET_HIGHZ = S_OFF | S_BIAS | S_RATE | S_RETRY;   // Output floats

  // ==========================================================
  // State, timers and decoded levels
  reg [ST_W-1:0]  state_r;               // Current state
  reg [ST_W-1:0]  state_nxt;             // Next state
  reg [TMR_W-1:0] tmr_r;                 // Shared state timer
  reg [TMR_W-1:0] ocTmr_r;               // Current limit timer
  reg             shutReq;               // Decoded shutdown request
  reg             stbyReq;               // Decoded standby request
  reg             tripHit;               // Output must turn off now
  wire            ovConf;                // Filtered over-voltage
  wire            uvConf;                // Filtered under-voltage
  wire            filtClr;               // Filters held clear outside delay and run
  reg             lowNxt;                // Next state is off or bias
  reg             convNxt;               // Next state switches
  reg             hizNxt;                // Next state floats the output

  // Timer reached count (shared compare)
  function tmrDone;
    input [TMR_W-1:0] t;
    input [TMR_W-1:0] lim;
    begin
      tmrDone = (t >= lim - 1'b1);
    end
  endfunction

  // Set membership of a one-hot state code
  // Cheaper than a chain of equality compares.
  function inSet;
    input [ST_W-1:0] st;
    input [ST_W-1:0] grp;
    begin
      inSet = (st & grp) != {ST_W{1'b0}};
    end
  endfunction

  // ==========================================================
  // Request decode
  // Shutdown outranks standby; supply loss treated as shutdown.
  // Levels only: a floating pin reads high, i.e. released.
  always @* begin
    shutReq = !shutdown_request_n || !supplyInRange;
    stbyReq = !standby_request_n && !shutReq;
  end

  // ==========================================================
  // Voltage fault filters
  // Only meaningful while the loop regulates; cleared otherwise.
  // One length for both; agreement with the output restarts it.
  assign filtClr = !(state_r == S_RUN || state_r == S_PGDLY);

  dts_seq_filter #(
    .CNT_W (8),
    .DELAY (FILT_CYC)
  ) u_ovFilt (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clear     (filtClr),
    .rawIn     (overVoltRaw),
    .filtOut_r (ovConf)
  );

  dts_seq_filter #(
    .CNT_W (8),
    .DELAY (FILT_CYC)
  ) u_uvFilt (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .clear     (filtClr),
    .rawIn     (underVoltRaw),
    .filtOut_r (uvConf)
  );

  // ==========================================================
  // Current limit timer
  // Runs while limiting; normal current before expiry restarts it.
  // Saturates at the limit so the trip stays asserted.
  always @(posedge ref_clk) begin
    if (!rstn || !converterEnable_r || !currentLimitHit) begin
      ocTmr_r <= {TMR_W{1'b0}};
    end else if (!tmrDone(ocTmr_r, OC_LIMIT_CYC[TMR_W-1:0])) begin
      ocTmr_r <= ocTmr_r + 1'b1;
    end
  end

  // Turn-off causes: timer expiry, short circuit at once, thermal
  // Thermal hysteresis is applied outside this block.
  always @* begin
    tripHit = shortCircuitHit
           || overTemp
           || (currentLimitHit && tmrDone(ocTmr_r, OC_LIMIT_CYC[TMR_W-1:0]));
  end

  // ==========================================================
  // Next-state logic
  // Order: off, bias, rate, soft, wait, delay, run.
  // Trips from any switching state lead to retry;
  // requests are applied last so they win everywhere.
  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_OFF: begin
        if (!shutReq && stbyReq) begin
          state_nxt = S_BIAS;
        end else if (!shutReq) begin
          state_nxt = S_BIAS;            // Bias first, then POR
        end
      end
      S_BIAS: begin
        if (shutReq) begin
          state_nxt = S_OFF;
        end else if (!stbyReq && tmrDone(tmr_r, BIAS_CYC[TMR_W-1:0])) begin
          state_nxt = S_RATE;
        end
      end
      S_RATE: begin
        // One cycle: pin read as POR lets go
        state_nxt = S_SOFT;
      end
      S_SOFT: begin
        // Ramp length set by the shared timer
        if (tripHit) begin
          state_nxt = S_RETRY;
        end else if (tmrDone(tmr_r, SS_CYC[TMR_W-1:0])) begin
          state_nxt = S_WAITREG;
        end
      end
      S_WAITREG: begin
        // No time limit; faults still trip
        if (tripHit) begin
          state_nxt = S_RETRY;
        end else if (outputInRegulation) begin
          state_nxt = S_PGDLY;
        end
      end
      S_PGDLY: begin
        // Voltage faults hold power-good, not the count
        if (tripHit) begin
          state_nxt = S_RETRY;
        end else if (tmrDone(tmr_r, PG_DELAY_CYC[TMR_W-1:0])) begin
          state_nxt = S_RUN;
        end
      end
      S_RUN: begin
        // Voltage faults stay in run, outputs active
        if (tripHit) begin
          state_nxt = S_RETRY;
        end
      end
      S_RETRY: begin
        // Thermal: wait for cool-down before the timeout counts
        if (tmrDone(tmr_r, RETRY_CYC[TMR_W-1:0]) && !overTemp) begin
          state_nxt = S_SOFT;
        end
      end
      default: begin
        // Illegal code: recover through shutdown
        state_nxt = S_OFF;
      end
    endcase
    // Requests override any sequence step
    if (shutReq) begin
      state_nxt = S_OFF;
    end else if (stbyReq) begin
      state_nxt = S_BIAS;
    end
  end

  // ==========================================================
  // State register and shared timer
  // Timer restarts on every state change, and stays cleared in retry
  // while hot so the timeout starts after the hysteresis.
  // Saturates, so a long standby leaves it parked high.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= S_OFF;
      tmr_r   <= {TMR_W{1'b0}};
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        tmr_r <= {TMR_W{1'b0}};
      end else if (state_r == S_RETRY && overTemp) begin
        tmr_r <= {TMR_W{1'b0}};
      end else if (!(&tmr_r)) begin
        tmr_r <= tmr_r + 1'b1;
      end
    end
  end

  // ==========================================================
  // Rate latch
  // Sampled once as POR releases; later pin changes are ignored.
  // Retries skip the rate state and keep the code.
  // A grounded pin reads code zero, the top rate.
  always @(posedge ref_clk) begin
    if (!rstn) begin
      rateLatched_r <= `DTS_RATE_TOP;
    end else if (state_r == S_RATE) begin
      rateLatched_r <= switch_rate_select;
    end
  end

  // ==========================================================
  // Next-state groups
  // Decoded once and shared by several enables below.
  always @* begin
    lowNxt  = inSet(state_nxt, SET_LOW);
    convNxt = inSet(state_nxt, SET_CONV);
    hizNxt  = inSet(state_nxt, SET_HIGHZ);
  end

  // ==========================================================
  // Registered outputs from the next state
  always @(posedge ref_clk) begin
    if (!rstn) begin
      biasEnable_r      <= 1'b0;
      porRelease_r      <= 1'b0;
      blocksEnable_r    <= 1'b0;
      converterEnable_r <= 1'b0;
      softStart_r       <= 1'b0;
      refOutEnable_r    <= 1'b0;
      termHighZ_r       <= 1'b1;
      termDischarge_r   <= 1'b0;
      refDischarge_r    <= 1'b0;
      cycleLimit_r      <= 1'b0;
      mode_r            <= `DTS_MODE_SHUTDOWN;
      faultStatus_r     <= 1'b0;
      power_ok_n_o_r    <= 1'b0;
      power_ok_n_oe_r   <= 1'b0;
    end else begin
      // Supplies and internal resets
      biasEnable_r      <= (state_nxt != S_OFF);
      porRelease_r      <= !lowNxt;
      blocksEnable_r    <= !lowNxt;
      // Converter and ramp
      converterEnable_r <= convNxt;
      softStart_r       <= (state_nxt == S_SOFT);
      // Output stage and discharge paths
      refOutEnable_r    <= (state_nxt != S_OFF);
      termHighZ_r       <= hizNxt;
      termDischarge_r   <= (state_nxt == S_OFF);
      refDischarge_r    <= (state_nxt == S_OFF);
      cycleLimit_r      <= currentLimitHit && convNxt;
      // Standby is reported only while it is requested
      if (state_nxt == S_OFF) begin
        mode_r <= `DTS_MODE_SHUTDOWN;
      end else if (state_nxt == S_BIAS && stbyReq) begin
        mode_r <= `DTS_MODE_STANDBY;
      end else begin
        mode_r <= `DTS_MODE_NORMAL;
      end
      // Status
      faultStatus_r     <= tripHit || ovConf || uvConf || (state_nxt == S_RETRY);
      // Pin is open drain: drive low or release to the pull-up
      // Released in start-up, standby, shutdown and retry
      power_ok_n_o_r    <= 1'b0;
      power_ok_n_oe_r   <= (state_nxt == S_RUN) && !tripHit
                           && !ovConf && !uvConf;
    end
  end

endmodule

// ### test/dts_seq_host.sv
// Host model: drives both request lines, resolves the power-good pin.
// Assumes requests change just after a rising ref_clk edge.
`timescale 1ns/1ps
module dts_seq_host (
  input  wire ref_clk,             // System clock
  input  wire power_ok_n_o_r,      // Pin data from the device
  input  wire power_ok_n_oe_r,     // Pin drive enable
  output reg  standby_request_n,   // Standby request, low active
  output reg  shutdown_request_n,  // Shutdown request, low active
  output reg  memSupplyUp,         // Memory supply on the sense input
  output wire powerOkPin           // Resolved pin level
);
  // ==========================================
  // Pin resolution
  // Pull-up wins whenever the device lets go
  assign powerOkPin = power_ok_n_oe_r ? power_ok_n_o_r : 1'b1;
  // Power applied in shutdown, memory supply up first
  initial begin
    shutdown_request_n = 1'b0;
    standby_request_n  = 1'b1;
    memSupplyUp        = 1'b1;
  end
  // ==========================================
  // Request driver
  // New levels at an edge, held until the next call
  task automatic setReq(input logic sd, input logic st);
    @(posedge ref_clk);
    shutdown_request_n <= sd;
    standby_request_n  <= st;
  endtask
endmodule

// ### test/dts_seq_chk.sv
// Checker for the sequencer, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "dts_seq_regs.vh"
module dts_seq_chk #(
  parameter PG_DELAY_CYC = 50,  // Power-good delay
  parameter FILT_CYC     = 20   // Voltage fault filter
) (
  input wire       ref_clk, rstn, standby_request_n, shutdown_request_n, supplyInRange,
  input wire       outputInRegulation, overVoltRaw, underVoltRaw, shortCircuitHit,
  input wire       power_ok_n_oe_r, biasEnable_r, porRelease_r, blocksEnable_r,
  input wire       converterEnable_r, softStart_r, refOutEnable_r, termHighZ_r,
  input wire       termDischarge_r, refDischarge_r,
  input wire [1:0] mode_r
);
  // ==========================================
  // Helper counters
  int regCnt;  // Cycles running in regulation
  int uvCnt;   // Cycles of raw voltage fault
  // Counts restart whenever their condition drops
  always @(posedge ref_clk) begin
    if (!rstn) begin
      regCnt <= 0;
      uvCnt  <= 0;
    end else begin
      regCnt <= (converterEnable_r && !softStart_r && outputInRegulation && mode_r == 2'h0) ? regCnt + 1 : 0;
      uvCnt  <= (overVoltRaw || underVoltRaw) ? uvCnt + 1 : 0;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  AST_REQ_SHUT: assert property ((!shutdown_request_n || !supplyInRange) |=> mode_r == `DTS_MODE_SHUTDOWN)
    else $error("Shutdown request without shutdown mode");
  AST_REQ_STANDBY_REQUEST_N: assert property ((shutdown_request_n && supplyInRange && !standby_request_n)
    |=> mode_r == `DTS_MODE_STANDBY) else $error("Standby request without standby mode");
  AST_NORMAL_REQ: assert property (mode_r == `DTS_MODE_NORMAL
    |-> $past(shutdown_request_n) && $past(standby_request_n) && $past(supplyInRange))
    else $error("Normal mode without released requests");
  AST_PG_RUN: assert property (power_ok_n_oe_r
    |-> mode_r == `DTS_MODE_NORMAL && converterEnable_r && !softStart_r && !termHighZ_r)
    else $error("Power good outside settled run");
  AST_PG_DELAY: assert property ($rose(power_ok_n_oe_r) |-> regCnt >= PG_DELAY_CYC - 2)
    else $error("Power good before its delay");
  AST_STANDBY_REQUEST_N_OUT: assert property (mode_r == `DTS_MODE_STANDBY
    |-> termHighZ_r && !converterEnable_r && !termDischarge_r) else $error("Standby outputs wrong");
  AST_SHUT_OFF: assert property (mode_r == `DTS_MODE_SHUTDOWN
    |-> !converterEnable_r && !refOutEnable_r && !biasEnable_r) else $error("Shutdown left blocks on");
  AST_DISCH: assert property ((termDischarge_r || refDischarge_r) |-> mode_r == `DTS_MODE_SHUTDOWN)
    else $error("Discharge outside shutdown");
  AST_SS_ORDER: assert property ($rose(softStart_r) |-> porRelease_r && blocksEnable_r && biasEnable_r)
    else $error("Soft start before blocks released");
  AST_SC_TRIP: assert property ((shortCircuitHit && converterEnable_r)
    |=> !converterEnable_r && termHighZ_r && !power_ok_n_oe_r) else $error("Short circuit not tripped");
  AST_UV_FILT: assert property (uvCnt > FILT_CYC + 2 |-> !power_ok_n_oe_r)
    else $error("Voltage fault kept power good");
  // Main scenarios reached
  COV_PG: cover property ($rose(power_ok_n_oe_r));
  COV_TRIP: cover property ($fell(converterEnable_r) && mode_r == `DTS_MODE_NORMAL);
  COV_STANDBY_REQUEST_N: cover property (mode_r == `DTS_MODE_STANDBY);
endmodule
bind dts_seq_ctrl dts_seq_chk #(.PG_DELAY_CYC(PG_DELAY_CYC), .FILT_CYC(FILT_CYC)) dts_seq_chk_i (
  .ref_clk(ref_clk), .rstn(rstn), .standby_request_n(standby_request_n),
  .shutdown_request_n(shutdown_request_n), .supplyInRange(supplyInRange),
  .outputInRegulation(outputInRegulation), .overVoltRaw(overVoltRaw), .underVoltRaw(underVoltRaw),
  .shortCircuitHit(shortCircuitHit), .power_ok_n_oe_r(power_ok_n_oe_r), .biasEnable_r(biasEnable_r),
  .porRelease_r(porRelease_r), .blocksEnable_r(blocksEnable_r), .converterEnable_r(converterEnable_r),
  .softStart_r(softStart_r), .refOutEnable_r(refOutEnable_r), .termHighZ_r(termHighZ_r),
  .termDischarge_r(termDischarge_r), .refDischarge_r(refDischarge_r), .mode_r(mode_r));

// ### test/dts_seq_ctrl_tb_top.sv
// Self-checking bench of the sequencer with a host model.
// Assumes the checker binds itself; counts are shortened by parameters.
`timescale 1ns/1ps
`include "dts_seq_regs.vh"
module dts_seq_ctrl_tb_top;
  // ==========================================
  // Short counts keep the run brief
  localparam int PGD = 50, OCL = 40, RETRY = 60, SSC = 30, FILT = 20;
  reg        ref_clk, rstn, supplyInRange, outputInRegulation;  // Clock and levels
  reg        overVoltRaw, underVoltRaw, currentLimitHit;        // Fault inputs
  reg        shortCircuitHit, overTemp;                         // Hard faults
  reg  [3:0] rateSel;                                           // Rate pin code
  wire       stbyN, sdN, memUp, powerOkPin, powerOkO, powerOkOe;  // Host side
  wire       biasEn, porRel, blocksEn, convEn, softSt, refEn;   // Enables
  wire       termHz, termDis, refDis, cycLim, faultSt;          // Output controls
  wire [3:0] rateL;                                             // Latched rate
  wire [1:0] modeR;                                             // Mode report
  int        err_count, total_checks, supM, g;                  // Bookkeeping
  logic [3:0] code;                                             // Random rate code
  dts_seq_ctrl #(.PG_DELAY_CYC(PGD), .OC_LIMIT_CYC(OCL), .RETRY_CYC(RETRY), .SS_CYC(SSC),
    .BIAS_CYC(10), .FILT_CYC(FILT)) dts_seq_ctrl_i (
    .ref_clk(ref_clk), .rstn(rstn), .standby_request_n(stbyN), .shutdown_request_n(sdN),
    .supplyInRange(supplyInRange), .switch_rate_select(rateSel), .outputInRegulation(outputInRegulation),
    .overVoltRaw(overVoltRaw), .underVoltRaw(underVoltRaw), .currentLimitHit(currentLimitHit),
    .shortCircuitHit(shortCircuitHit), .overTemp(overTemp), .power_ok_n_o_r(powerOkO),
    .power_ok_n_oe_r(powerOkOe), .biasEnable_r(biasEn), .porRelease_r(porRel), .blocksEnable_r(blocksEn),
    .converterEnable_r(convEn), .softStart_r(softSt), .refOutEnable_r(refEn), .termHighZ_r(termHz),
    .termDischarge_r(termDis), .refDischarge_r(refDis), .cycleLimit_r(cycLim), .rateLatched_r(rateL),
    .mode_r(modeR), .faultStatus_r(faultSt));
  dts_seq_host dts_seq_host_i (.ref_clk(ref_clk), .power_ok_n_o_r(powerOkO), .power_ok_n_oe_r(powerOkOe),
    .standby_request_n(stbyN), .shutdown_request_n(sdN), .memSupplyUp(memUp), .powerOkPin(powerOkPin));
  // ==========================================
  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Far longer than the sequence needs
  initial begin
    repeat (6000) @(posedge ref_clk);
    err_count++;
    results();
  end
  // ==========================================
  // Model and helpers
  // Shutdown or low supply beats standby
  function automatic int expMode(int sd, int st, int sup);
    return (sd == 0 || sup == 0) ? 2 : (st == 0) ? 1 : 0;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // Bounded wait on soft start, power good or converter
  task automatic waitSig(input int sel, input logic want, input int lim, output int n);
    logic v;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      v = (sel == 0) ? softSt : (sel == 1) ? powerOkOe : convEn;
    end while (v !== want && n < lim);
    chk("waitDone", 1, v === want);
  endtask
  task automatic applyReq(input logic sd, input logic st, input logic sup);
    dts_seq_host_i.setReq(sd, st);
    supplyInRange <= sup;
    supM = sup;
    @(posedge ref_clk);
    #1 chk("mode", expMode(sd, st, supM), modeR);
  endtask
  // Full start from a low-power mode to power good
  task automatic startRun(input logic [3:0] c);
    int n;
    @(posedge ref_clk);
    rateSel <= c;
    outputInRegulation <= 1'b0;
    applyReq(1'b1, 1'b1, 1'b1);
    waitSig(0, 1'b1, 40, n);
    chk("rateLatched", c, rateL);
    chk("porRelease", 1, porRel && blocksEn);
    chk("termHighZ", 0, termHz | termDis);
    waitSig(0, 1'b0, SSC + 5, n);
    chk("softStartLen", 1, n >= SSC - 1);
    chk("pgEarly", 0, powerOkOe);
    @(posedge ref_clk);
    outputInRegulation <= 1'b1;
    waitSig(1, 1'b1, PGD + 5, n);
    chk("pgDelay", 1, n >= PGD - 1);
    chk("pgPin", 0, powerOkPin);
  endtask
  // Retry timeout, soft start, power good again
  task automatic recover();
    int n;
    waitSig(0, 1'b1, RETRY + 10, n);
    chk("retryWait", 1, n >= RETRY - 2);
    waitSig(1, 1'b1, SSC + PGD + 20, n);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hfd5a8bee));
    {rstn, outputInRegulation, overVoltRaw, underVoltRaw, currentLimitHit, shortCircuitHit, overTemp} = 7'h00;
    supplyInRange = 1'b1;
    rateSel = 4'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk("powerUpShut", {2'h2, 4'h3}, {modeR, biasEn, convEn, rateL == 4'h0, powerOkPin});
    applyReq(1'b1, 1'b0, 1'b1);
    chk("standbyBias", 4'h9, {biasEn, porRel, convEn, termHz});
    applyReq(1'b0, 1'b0, 1'b1);
    chk("discharge", 3'h6, {termDis, refDis, refEn});
    code = $urandom_range(1, 15);
    startRun(code);
    applyReq(1'b0, 1'b1, 1'b1);
    startRun(4'h0);
    g = $urandom_range(1, FILT - 3);
    @(posedge ref_clk);
    overVoltRaw <= 1'b1;
    repeat (g) @(posedge ref_clk);
    overVoltRaw <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("pgGlitch", 1, powerOkOe);
    @(posedge ref_clk);
    underVoltRaw <= 1'b1;
    repeat (FILT + 5) @(posedge ref_clk);
    #1 chk("uvHold", 2'h1, {powerOkOe, convEn});
    @(posedge ref_clk);
    underVoltRaw <= 1'b0;
    waitSig(1, 1'b1, FILT + 10, g);
    chk("uvReturn", 1, g >= FILT - 1);
    @(posedge ref_clk);
    shortCircuitHit <= 1'b1;
    @(posedge ref_clk);
    shortCircuitHit <= 1'b0;
    #1 chk("shortTrip", 4'h7, {convEn, termHz, faultSt, powerOkPin});
    recover();
    @(posedge ref_clk);
    currentLimitHit <= 1'b1;
    repeat (OCL - 10) @(posedge ref_clk);
    #1 chk("limitRun", 2'h3, {convEn, cycLim});
    waitSig(2, 1'b0, 20, g);
    chk("limitTrip", 1, powerOkPin);
    @(posedge ref_clk);
    currentLimitHit <= 1'b0;
    recover();
    @(posedge ref_clk);
    overTemp <= 1'b1;
    repeat (RETRY + 40) @(posedge ref_clk);
    #1 chk("hotHold", 2'h1, {convEn, softSt, faultSt});
    @(posedge ref_clk);
    overTemp <= 1'b0;
    recover();
    applyReq(1'b1, 1'b0, 1'b1);
    chk("standbyRun", 3'h5, {powerOkPin, convEn, refEn});
    applyReq(1'b1, 1'b1, 1'b1);
    waitSig(0, 1'b1, 40, g);
    applyReq(1'b1, 1'b1, 1'b0);
    results();
  end
endmodule
